// ==== hdl/three_wire_pkg.sv ====
/*
  Constants, types and helpers shared by the three-wire control port.
  Assumes a microcontroller-driven serial link (data, mode, clock lines)
  and a register file on the MCLK side with single-cycle read data.
*/
// Summary of operation
// - address byte shifts least significant bit first, register and data bytes most significant bit first
// - mode low plus eight clocks selects device
// - mode high carries register, instruction, data bytes
// - address byte: type code, six-bit device address
// - address bits two, three come from pins
// - respond only to own six-bit device address
// - code 10 write/prepare, 11 read, others unused
// - register byte: rw flag plus seven-bit address
// - rw flag zero means register write follows
// - rw flag one latches source for read
// - read returns address/valid flag, then data bytes
// - pcm detect high only for pcm data
// - lock high when locked and pcm present
// - read is four bytes, high data byte first
package three_wire_pkg;

  localparam int BYTE_BITS  = 8;
  localparam int REG_ADDR_W = 7;
  localparam int DATA_W     = 16;
  localparam int TX_BITS    = 3 * BYTE_BITS;

  // ----------------------------------------------------------------
  // address byte layout, bit 0 is the first bit on the wire
  // ----------------------------------------------------------------
  localparam int       TYPE_LSB     = 0;
  localparam int       SEL_LSB      = 2;
  localparam int       FIXED_LSB    = 4;
  localparam logic [3:0] FIXED_ADDR = 4'h1;
  localparam logic [1:0] TT_WRITE   = 2'h2;
  localparam logic [1:0] TT_READ    = 2'h3;
  localparam int       RW_BIT       = 0;

  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] SEND_LAST  = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REG  = 6'h02,
    ST_HI   = 6'h04,
    ST_LO   = 6'h08,
    ST_SEND = 6'h10,
    ST_SKIP = 6'h20
  } link_state_t;

  // wire order is first bit = bit 0, but register and data fields put
  // their most significant bit first, so bytes are mirrored
  function automatic logic [7:0] rev8(input logic [7:0] x);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = x[7-i];
    end
    return r;
  endfunction

endpackage

// ==== hdl/bit_sync.sv ====
/*
  Two-stage synchroniser for levels, any width.
  Assumes each bit changes slowly compared with the receiving clock.
*/
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         rst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta is read by q only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ==== hdl/toggle_pulse.sv ====
/*
  Toggle-to-pulse event crossing.
  Assumes the source flips tog once per event, with events spaced by
  several destination clocks, and holds its payload stable meanwhile.
*/
`timescale 1ns/1ps
module toggle_pulse (
  input  logic clk,
  input  logic rst,
  input  logic tog,
  output logic pulse
);
  logic synced;
  logic last;

  bit_sync #(.W(1)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (tog),
    .q   (synced)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      last  <= 1'b0;
      pulse <= 1'b0;
    end else begin
      last  <= synced;
      pulse <= synced ^ last;
    end
  end
endmodule

// ==== hdl/three_wire_control_port.sv ====
/*
  Slave end of the three-wire serial control port, plus the pcm detect
  and lock status pins. Link logic runs on the master's clock line;
  register writes and read fetches are handed to the MCLK domain.
  Assumes the register file answers RD_REQ with RD_DATA/RD_INVALID in
  the cycle RD_REQ is high, and that the status inputs are MCLK-timed.
*/
`timescale 1ns/1ps
module three_wire_control_port (
  input  logic                                MCLK,
  input  logic                                RST,
  input  logic                                CTRL_CLOCK_LINE,
  input  logic                                CTRL_MODE_LINE,
  input  logic                                CTRL_DATA_IN,
  output logic                                CTRL_DATA_OUT,
  output logic                                CTRL_DATA_OE,
  input  logic                                ADDR_SELECT_PIN0,
  input  logic                                ADDR_SELECT_PIN1,
  output logic                                WR_STROBE,
  output logic [three_wire_pkg::REG_ADDR_W-1:0] WR_ADDR,
  output logic [three_wire_pkg::DATA_W-1:0]   WR_DATA,
  output logic                                RD_REQ,
  output logic [three_wire_pkg::REG_ADDR_W-1:0] RD_ADDR,
  input  logic [three_wire_pkg::DATA_W-1:0]   RD_DATA,
  input  logic                                RD_INVALID,
  input  logic                                PCM_SEEN,
  input  logic                                BURST_SEEN,
  input  logic                                CLOCK_LOCKED,
  input  logic                                DECODER_LOCKED,
  output logic                                PCM_DETECT_OUT,
  output logic                                LOCK_OUT
);
  import three_wire_pkg::*;

  // ----------------------------------------------------------------
  // link-domain reset and strap pins
  // ----------------------------------------------------------------
  logic                  lrst;
  logic [1:0]            sel;

  // the link clock only runs when the master clocks it, so reset
  // takes effect on its first pulses: the wake pulse serves this
  bit_sync #(.W(1)) u_rst_sync (
    .clk (CTRL_CLOCK_LINE),
    .rst (1'b0),
    .d   (RST),
    .q   (lrst)
  );

  bit_sync #(.W(2)) u_sel_sync (
    .clk (CTRL_CLOCK_LINE),
    .rst (lrst),
    .d   ({ADDR_SELECT_PIN1, ADDR_SELECT_PIN0}),
    .q   (sel)
  );

  // ----------------------------------------------------------------
  // byte framing on the link
  // ----------------------------------------------------------------
  link_state_t             state;
  link_state_t             next_state;
  logic                    prev_mode;
  logic [2:0]              bit_cnt;
  logic [7:0]              sr;
  logic [1:0]              snd_cnt;
  logic [TX_BITS-1:0]      tx;
  logic [REG_ADDR_W-1:0]   wr_addr_l;
  logic [REG_ADDR_W-1:0]   rd_addr_l;
  logic [DATA_W-1:0]       wr_data_l;
  logic                    wr_tog;
  logic                    rd_tog;
  logic [DATA_W-1:0]       rd_word;
  logic                    rd_invalid;

  wire                     new_frame = CTRL_MODE_LINE != prev_mode;
  wire  [2:0]              cur_cnt   = new_frame ? 3'h0 : bit_cnt;
  wire  [7:0]              next_sr   = {CTRL_DATA_IN, sr[7:1]};
  wire                     byte_done = cur_cnt == LAST_BIT;
  wire  [7:0]              mirrored  = rev8(next_sr);
  wire  [1:0]              transfer_type_code = next_sr[TYPE_LSB +: 2];
  wire                     addr_hit  = next_sr[FIXED_LSB +: 4] == FIXED_ADDR
                                     && next_sr[SEL_LSB +: 2] == sel;
  wire                     addr_end  = byte_done && !CTRL_MODE_LINE;
  wire                     data_end  = byte_done && CTRL_MODE_LINE;
  wire                     read_go   = addr_end && addr_hit && transfer_type_code == TT_READ;
  wire                     is_prep   = next_sr[RW_BIT];

  // a mode change always restarts the bit count, so a stray clock
  // cannot misalign every later byte
  always_ff @(posedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      prev_mode <= 1'b0;
      bit_cnt   <= 3'h0;
      sr        <= 8'h00;
    end else begin
      prev_mode <= CTRL_MODE_LINE;
      bit_cnt   <= cur_cnt + 3'h1;
      sr        <= next_sr;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (addr_end) begin
      if (addr_hit && transfer_type_code == TT_WRITE) begin
        next_state = ST_REG;
      end else if (read_go) begin
        next_state = ST_SEND;
      end else begin
        next_state = ST_IDLE;
      end
    end else if (data_end) begin
      case (state)
        ST_REG:  next_state = is_prep ? ST_SKIP : ST_HI;
        ST_HI:   next_state = ST_LO;
        ST_LO:   next_state = ST_SKIP;
        ST_SEND: next_state = snd_cnt == SEND_LAST ? ST_SKIP : ST_SEND;
        ST_IDLE: next_state = ST_IDLE;
        ST_SKIP: next_state = ST_SKIP;
        default: next_state = ST_IDLE;
      endcase
    end else if (state == ST_SEND && new_frame && !CTRL_MODE_LINE) begin
      // master went back to address mode mid-read: stop driving
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // register byte and write data capture
  // ----------------------------------------------------------------
  always_ff @(posedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      wr_addr_l <= '0;
      rd_addr_l <= '0;
    end else if (data_end && state == ST_REG) begin
      if (is_prep) begin
        rd_addr_l <= mirrored[REG_ADDR_W-1:0];
      end else begin
        wr_addr_l <= mirrored[REG_ADDR_W-1:0];
      end
    end
  end

  // toggles flip on the same edge as the payload's last update; the MCLK side
  // sees them cycles later and can take the payload without its own synchroniser
  always_ff @(posedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      wr_data_l <= '0;
      wr_tog    <= 1'b0;
      rd_tog    <= 1'b0;
    end else if (data_end) begin
      if (state == ST_HI) begin
        wr_data_l[DATA_W-1 -: 8] <= mirrored;
      end
      if (state == ST_LO) begin
        wr_data_l[7:0] <= mirrored;
        wr_tog         <= ~wr_tog;
      end
      if (state == ST_REG && is_prep) begin
        rd_tog <= ~rd_tog;
      end
    end
  end

  // ----------------------------------------------------------------
  // read answer: flag byte, then high and low data bytes
  // ----------------------------------------------------------------
  // rd_word is quasi-static: it settles a few MCLK cycles after the
  // prepare byte and long before the read-type address byte ends
  always_ff @(posedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      tx      <= '0;
      snd_cnt <= 2'h0;
    end else if (read_go) begin
      tx      <= {rev8(rd_word[7:0]), rev8(rd_word[DATA_W-1 -: 8]),
                  rev8({rd_invalid, rd_addr_l})};
      snd_cnt <= 2'h0;
    end else if (state == ST_SEND && CTRL_MODE_LINE) begin
      tx      <= {1'b0, tx[TX_BITS-1:1]};
      if (byte_done) begin
        snd_cnt <= snd_cnt + 2'h1;
      end
    end
  end

  // drive on the falling edge so the bit is stable at the master's
  // rising-edge sample; released whenever no read is in progress
  always_ff @(negedge CTRL_CLOCK_LINE) begin
    if (lrst) begin
      CTRL_DATA_OUT <= 1'b0;
      CTRL_DATA_OE  <= 1'b0;
    end else begin
      CTRL_DATA_OUT <= tx[0];
      CTRL_DATA_OE  <= state == ST_SEND;
    end
  end

  // ----------------------------------------------------------------
  // MCLK side: write strobe and read fetch
  // ----------------------------------------------------------------
  logic                    wr_pulse;
  logic                    rd_pulse;

  toggle_pulse u_wr_event (
    .clk   (MCLK),
    .rst   (RST),
    .tog   (wr_tog),
    .pulse (wr_pulse)
  );

  toggle_pulse u_rd_event (
    .clk   (MCLK),
    .rst   (RST),
    .tog   (rd_tog),
    .pulse (rd_pulse)
  );

  always_ff @(posedge MCLK) begin
    if (RST) begin
      WR_STROBE <= 1'b0;
      WR_ADDR   <= '0;
      WR_DATA   <= '0;
    end else begin
      WR_STROBE <= wr_pulse;
      if (wr_pulse) begin
        WR_ADDR <= wr_addr_l;
        WR_DATA <= wr_data_l;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      RD_REQ     <= 1'b0;
      RD_ADDR    <= '0;
      rd_word    <= '0;
      rd_invalid <= 1'b0;
    end else begin
      RD_REQ <= rd_pulse;
      if (rd_pulse) begin
        RD_ADDR <= rd_addr_l;
      end
      if (RD_REQ) begin
        rd_word    <= RD_DATA;
        rd_invalid <= RD_INVALID;
      end
    end
  end

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  wire                     pcm_now  = PCM_SEEN && !BURST_SEEN;
  wire                     lock_now = CLOCK_LOCKED && DECODER_LOCKED && pcm_now;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PCM_DETECT_OUT <= 1'b0;
      LOCK_OUT       <= 1'b0;
    end else begin
      PCM_DETECT_OUT <= pcm_now;
      LOCK_OUT       <= lock_now;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bit_wrap: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (CTRL_MODE_LINE == prev_mode && bit_cnt == LAST_BIT) |=> bit_cnt == 3'h0)
    else $error("bit count did not wrap after eight bits");

  a_select_write: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (addr_end && addr_hit && transfer_type_code == TT_WRITE) |=> state == ST_REG)
    else $error("matching write address byte did not select");

  a_pin_mismatch: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (addr_end && next_sr[SEL_LSB +: 2] != sel) |=> state == ST_IDLE)
    else $error("address with wrong select pins was accepted");

  a_unused_code: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (addr_end && !transfer_type_code[1]) |=> state == ST_IDLE)
    else $error("unused transfer type code was accepted");

  a_write_event: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (data_end && state == ST_LO) |=> wr_tog != $past(wr_tog) && state == ST_SKIP)
    else $error("fourth write byte did not raise a write event");

  a_prep_latch: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    (data_end && state == ST_REG && is_prep)
      |=> rd_addr_l == $past(mirrored[REG_ADDR_W-1:0]) && rd_tog != $past(rd_tog))
    else $error("prepare read did not latch the source address");

  a_flag_first: assert property (
    @(posedge CTRL_CLOCK_LINE) disable iff (lrst)
    read_go |=> tx[0] == $past(rd_invalid) && tx[1] == rd_addr_l[REG_ADDR_W-1])
    else $error("read answer does not start with the valid flag");

  a_foreign_quiet: assert property (
    @(negedge CTRL_CLOCK_LINE) disable iff (lrst)
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> !CTRL_DATA_OE)
    else $error("data line driven while not addressed");

  a_fetch_pair: assert property (
    @(posedge MCLK) disable iff (RST)
    rd_pulse |=> RD_REQ ##1 rd_word == $past(RD_DATA))
    else $error("read fetch did not capture register data");

  a_strobe_single: assert property (
    @(posedge MCLK) disable iff (RST)
    WR_STROBE |=> !WR_STROBE)
    else $error("write strobe longer than one cycle");

  a_lock_pcm: assert property (
    @(posedge MCLK) disable iff (RST)
    LOCK_OUT |-> PCM_DETECT_OUT && $past(CLOCK_LOCKED) && $past(DECODER_LOCKED))
    else $error("lock shown without pcm or without both locks");

  a_pcm_follow: assert property (
    @(posedge MCLK) disable iff (RST)
    $past(BURST_SEEN) |-> !PCM_DETECT_OUT)
    else $error("pcm detect high while a burst preamble is seen");

endmodule

// ==== verif/uc_master_model.sv ====
/*
  Behavioural microcontroller on the far side of the three-wire port.
  Assumes the device drives on the falling clock edge, and that the
  bench calls these tasks one at a time.
*/
`timescale 1ns/1ps
module uc_master_model (
  output logic clk_line,
  output logic mode_line,
  output logic data_wire,
  input  logic dev_out,
  input  logic dev_oe
);
  localparam realtime HALF = 7.5;
  logic drv;
  logic drv_d;
  logic junk;

  // a released line shows a changing pattern, never the last bit driven
  assign data_wire = dev_oe ? dev_out : (drv ? drv_d : junk);

  initial begin
    clk_line  = 1'b1;
    mode_line = 1'b1;
    drv       = 1'b0;
    drv_d     = 1'b0;
    junk      = 1'b0;
  end

  always @(negedge clk_line) begin
    junk <= ~junk;
  end

  // ----------------------------------------------------------------
  // bit and byte level
  // ----------------------------------------------------------------
  function automatic logic [7:0] mir(input logic [7:0] x);
    return {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
  endfunction

  task automatic wake(input int n);
    drv = 1'b0;
    repeat (n) begin
      clk_line = 1'b0;
      #HALF;
      clk_line = 1'b1;
      #HALF;
    end
  endtask

  task automatic put_byte(input logic m, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      clk_line  = 1'b0;
      mode_line = m;
      drv       = 1'b1;
      drv_d     = b[i];
      #HALF;
      clk_line = 1'b1;
      #HALF;
    end
    drv = 1'b0;
  endtask

  task automatic get_byte(output logic [7:0] b);
    mode_line = 1'b1;
    drv       = 1'b0;
    for (int i = 0; i < 8; i++) begin
      clk_line = 1'b0;
      #HALF;
      clk_line = 1'b1;
      b[i]     = data_wire;
      #HALF;
    end
  endtask

  // ----------------------------------------------------------------
  // transfers: the device byte is always sent again first
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [7:0] dev, input logic [6:0] a, input logic [15:0] d);
    put_byte(1'b0, dev);
    put_byte(1'b1, mir({1'b0, a}));
    put_byte(1'b1, mir(d[15:8]));
    put_byte(1'b1, mir(d[7:0]));
  endtask

  task automatic prepare(input logic [7:0] dev, input logic [6:0] a);
    put_byte(1'b0, dev);
    put_byte(1'b1, mir({1'b1, a}));
  endtask

  task automatic read_back(input logic [7:0] dev, output logic inv, output logic [6:0] a,
                           output logic [15:0] d);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    put_byte(1'b0, dev);
    get_byte(b0);
    get_byte(b1);
    get_byte(b2);
    {inv, a} = mir(b0);
    d        = {mir(b1), mir(b2)};
  endtask
endmodule

// ==== verif/three_wire_control_port_tb.sv ====
/*
  Self-checking bench for the three-wire control port.
  Assumes uc_master_model drives the link; the bench plays the register
  file and the status sources on the MCLK side.
*/
`timescale 1ns/1ps
module three_wire_control_port_tb;
  import three_wire_pkg::*;

  logic                  mclk;
  logic                  rst;
  logic                  pin0;
  logic                  pin1;
  logic [DATA_W-1:0]     rd_data;
  logic                  rd_invalid;
  logic                  pcm_seen;
  logic                  burst_seen;
  logic                  clock_locked;
  logic                  decoder_locked;
  logic                  wr_strobe;
  logic [REG_ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic                  rd_req;
  logic [REG_ADDR_W-1:0] rd_addr;
  logic                  pcm_detect_out;
  logic                  lock_out;
  logic                  data_out;
  logic                  data_oe;
  logic                  clk_line;
  logic                  mode_line;
  logic                  data_wire;
  int                    n_fail = 0;
  int                    total_checks = 0;
  int                    oe_rise = 0;

  initial begin
    mclk = 1'b0;
    rst  = 1'b1;
    {pin0, pin1, rd_data, rd_invalid} = '0;
    {pcm_seen, burst_seen, clock_locked, decoder_locked} = 4'h0;
  end
  always #50 mclk = ~mclk;
  always @(posedge data_oe) oe_rise++;

  three_wire_control_port u_three_wire_control_port (
    .MCLK(mclk), .RST(rst), .CTRL_CLOCK_LINE(clk_line), .CTRL_MODE_LINE(mode_line),
    .CTRL_DATA_IN(data_wire), .CTRL_DATA_OUT(data_out), .CTRL_DATA_OE(data_oe),
    .ADDR_SELECT_PIN0(pin0), .ADDR_SELECT_PIN1(pin1), .WR_STROBE(wr_strobe),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .RD_INVALID(rd_invalid), .PCM_SEEN(pcm_seen),
    .BURST_SEEN(burst_seen), .CLOCK_LOCKED(clock_locked),
    .DECODER_LOCKED(decoder_locked), .PCM_DETECT_OUT(pcm_detect_out), .LOCK_OUT(lock_out)
  );

  uc_master_model u_uc_master_model (
    .clk_line(clk_line), .mode_line(mode_line), .data_wire(data_wire),
    .dev_out(data_out), .dev_oe(data_oe)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] dev(input logic [1:0] code, input logic p0, input logic p1);
    return {3'h0, 1'b1, p1, p0, code};
  endfunction

  task automatic wait_ev(input logic rd, output logic got);
    got = 1'b0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if ((rd ? rd_req : wr_strobe) === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  task automatic set_pins(input logic p0, input logic p1);
    @(posedge mclk);
    pin0 <= p0;
    pin1 <= p1;
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write;
    logic        got;
    logic [6:0]  a;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      set_pins(i[0], i[1]);
      a = 7'h41 ^ i[6:0];
      d = 16'ha5c3 ^ {4{i[3:0]}};
      u_uc_master_model.write_reg(dev(2'h2, i[0], i[1]), a, d);
      wait_ev(1'b0, got);
      check(16'(got), 16'h1, "write strobe");
      check(16'(wr_addr), 16'(a), "write address");
      check(wr_data, d, "write data");
      repeat (10) @(posedge mclk);
    end
    check(16'(oe_rise), 16'h0, "drive during write");
    $display("test write done");
  endtask

  // two bytes past the fourth would form a second write if the frame were not closed
  task automatic t_extra;
    logic got;
    set_pins(1'b0, 1'b0);
    u_uc_master_model.write_reg(dev(2'h2, 1'b0, 1'b0), 7'h33, 16'h5aa5);
    wait_ev(1'b0, got);
    check(16'(got), 16'h1, "write before extra bytes");
    u_uc_master_model.put_byte(1'b1, 8'h3c);
    u_uc_master_model.put_byte(1'b1, 8'hc3);
    wait_ev(1'b0, got);
    check(16'(got), 16'h0, "bytes after the fourth");
    check(wr_data, 16'h5aa5, "write data kept");
    $display("test extra bytes done");
  endtask

  task automatic t_ignore;
    logic got;
    set_pins(1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      u_uc_master_model.write_reg((k == 0) ? dev(2'h2, 1'b0, 1'b0)
                                           : dev(k[1:0] - 2'h1, 1'b1, 1'b0), 7'h15, 16'h0ff0);
      wait_ev(1'b0, got);
      check(16'(got), 16'h0, "ignored write");
    end
    $display("test ignore done");
  endtask

  task automatic t_read(input logic inv, input logic [6:0] a, input logic [15:0] d);
    logic        got;
    logic        f;
    logic [6:0]  ra;
    logic [15:0] rv;
    set_pins(1'b0, 1'b1);
    @(posedge mclk);
    rd_data    <= d;
    rd_invalid <= inv;
    u_uc_master_model.prepare(dev(2'h2, 1'b0, 1'b1), a);
    wait_ev(1'b1, got);
    check(16'(got), 16'h1, "prepare fetch");
    check(16'(rd_addr), 16'(a), "prepare address");
    repeat (10) @(posedge mclk);
    u_uc_master_model.read_back(dev(2'h3, 1'b0, 1'b1), f, ra, rv);
    check(16'(f), 16'(inv), "valid flag");
    check(16'(ra), 16'(a), "echoed address");
    check(rv, d, "read data");
    $display("test read done");
  endtask

  task automatic t_read_miss;
    logic        got;
    logic        f;
    logic [6:0]  ra;
    logic [15:0] rv;
    int          r0;
    r0 = oe_rise;
    u_uc_master_model.prepare(dev(2'h2, 1'b1, 1'b1), 7'h22);
    wait_ev(1'b1, got);
    check(16'(got), 16'h0, "foreign prepare");
    u_uc_master_model.read_back(dev(2'h3, 1'b1, 1'b1), f, ra, rv);
    check(16'(oe_rise - r0), 16'h0, "foreign read drive");
    $display("test read miss done");
  endtask

  task automatic t_status;
    logic pcm;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      {pcm_seen, burst_seen, clock_locked, decoder_locked} <= i[3:0];
      repeat (2) @(posedge mclk);
      #1;
      pcm = i[3] & ~i[2];
      check(16'(pcm_detect_out), 16'(pcm), "pcm detect");
      check(16'(lock_out), 16'(pcm & i[1] & i[0]), "lock");
    end
    $display("test status done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #3;
    u_uc_master_model.wake(5);
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check(16'({wr_strobe, rd_req, data_oe}), 16'h0, "reset outputs");
    u_uc_master_model.wake(3);
    t_write();
    t_extra();
    t_ignore();
    t_read(1'b0, 7'h5a, 16'h8e31);
    t_read(1'b1, 7'h07, 16'h1c4f);
    t_read_miss();
    t_status();
    summarize();
  end

  initial begin
    #200us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule
